// File: grr_params.svh
`ifndef GRR_PARAMS_SVH
`define GRR_PARAMS_SVH
// ==========================================================================

// ==========================================================================
// command codes
`define GRR_CMD_INV 8'hF4
`define GRR_CMD_SEL14 8'hF5
`define GRR_CMD_SEL58 8'hF6
`define GRR_CMD_GPI 8'hF7
`define GRR_CMD_RBT 8'hFD

// ==========================================================================
// reset values and writable masks
`define GRR_RST_INV 16'h009B
`define GRR_RST_SEL14 16'h5F43
`define GRR_RST_SEL58 16'h8207
`define GRR_RST_GPI 16'h0005
`define GRR_RST_RBT 8'h00
`define GRR_MSK_INV 16'h02FF
`define GRR_MSK_GPI 16'h00F7
`define GRR_MSK_RBT 8'h38

// ==========================================================================
// field positions
`define GRR_GPI_EN_BIT 7
`define GRR_GPI_RSEL_LSB 4
`define GRR_GPI_CSEL_LSB 0
`define GRR_INV_RPOL_BIT 9
`define GRR_RBT_REQ_BIT 3
`define GRR_REBOOT_INIT_OPTION_LSB 4

// ==========================================================================
// selector codes
`define GRR_SRC_OFF 4'h0
`define GRR_SRC_DATA 4'h1
`define GRR_SRC_CMP 4'h2
`define GRR_SRC_PG 4'h3
`define GRR_SRC_FLT 4'h4
`define GRR_SRC_OC 4'h5
`define GRR_SRC_OPS 4'h8
`define GRR_SRC_ALT 4'h9
`define GRR_SRC_LALT 4'hA
`define GRR_SRC_TEMP 4'hF
`define GRR_TEMP_PIN 2
`define GRR_INIT_NORESET 2'h2

// ==========================================================================
// timing
`define GRR_MIN_OFF_MS 500
`define GRR_CLK_NS 8
`define GRR_OFF_DELAY_CYC (`GRR_MIN_OFF_MS * 1000000 / `GRR_CLK_NS)
`endif

// File: grr_pkg.sv
package grr_pkg;
    typedef struct packed {
        logic temperature;
        logic latched_alert;
        logic alert;
        logic operation_status_one;
        logic overcurrent_status;
        logic fault;
        logic power_good_flag;
        logic comparator_result;
    } grr_src_t;

    typedef enum logic [2:0] {
        st_idle = 3'b001,
        st_off = 3'b010,
        st_on = 3'b100
    } grr_state_t;

    typedef struct packed {
        logic fet_off;
        logic chip_reset;
        logic busy;
    } grr_seq_t;
endpackage : grr_pkg

// File: grr_reboot_seq.sv
`include "grr_params.svh"

module grr_reboot_seq import grr_pkg::*; #(
    parameter int unsigned OFF_DELAY_CYC = `GRR_OFF_DELAY_CYC
) (
    input wire logic mclk_in,
    input wire logic rst_n_in,
    input wire logic start_in,
    input wire logic [1:0] init_opt_in,
    output grr_seq_t seq_out
);
    grr_state_t state_ff;
    logic [31:0] cnt_ff;
    logic no_reset_ff;
    logic chip_reset_ff;

    // ======================================================================
    // sequence
    always_ff @(posedge mclk_in) begin
        if (!rst_n_in) begin
            state_ff <= st_idle;
            cnt_ff <= 32'h0;
            no_reset_ff <= 1'b0;
        end else begin
            case (state_ff)
                st_idle: begin
                    if (start_in) begin
                        state_ff <= st_off;
                        cnt_ff <= 32'(OFF_DELAY_CYC - 1);
                        // option latched so a later write cannot change it
                        no_reset_ff <= (init_opt_in == `GRR_INIT_NORESET);
                    end
                end
                st_off: begin
                    if (cnt_ff == 32'h0) begin
                        state_ff <= st_on;
                    end else begin
                        cnt_ff <= cnt_ff - 32'h1;
                    end
                end
                st_on: state_ff <= st_idle;
                default: state_ff <= st_idle;
            endcase
        end
    end

    always_ff @(posedge mclk_in) begin
        if (!rst_n_in) begin
            chip_reset_ff <= 1'b0;
        end else begin
            chip_reset_ff <= (state_ff == st_off) && (cnt_ff == 32'h0)
                && !no_reset_ff;
        end
    end

    assign seq_out.fet_off = (state_ff == st_off);
    assign seq_out.chip_reset = chip_reset_ff;
    assign seq_out.busy = (state_ff != st_idle);

    // ======================================================================
    // checks
    off_hold_a: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
        $rose(seq_out.fet_off) |-> seq_out.fet_off [*8])
        else $error("fet off released too early");
    reset_opt_a: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
        seq_out.chip_reset |-> !no_reset_ff && $past(seq_out.fet_off))
        else $error("chip reset with no-reset option");
endmodule : grr_reboot_seq

// File: grr_route_reboot.sv
`include "grr_params.svh"

module grr_route_reboot import grr_pkg::*; #(
    parameter int unsigned OFF_DELAY_CYC = `GRR_OFF_DELAY_CYC
) (
    input wire logic mclk_in,
    input wire logic rst_n_in,
    input wire logic reg_wr_in,
    input wire logic reg_rd_in,
    input wire logic [7:0] reg_cmd_in,
    input wire logic [15:0] reg_wdata_in,
    output logic [15:0] reg_rdata_out,
    output logic reg_ack_out,
    input wire logic [7:0] general_output_data_in,
    input wire grr_src_t status_src_in,
    input wire logic [7:0] gpio_pin_in,
    output logic [7:0] gpio_pin_out,
    output logic [7:0] gpio_pin_oe_out,
    output logic comparator_in_out,
    output logic fet_off_out,
    output logic chip_reset_out,
    output logic reboot_busy_out
);
    logic [15:0] inv_ff;
    logic [15:0] sel14_ff;
    logic [15:0] sel58_ff;
    logic [15:0] gpi_ff;
    logic [7:0] rbt_ff;
    logic [15:0] rdata_ff;
    logic ack_ff;
    logic [7:0] gpio_s1_ff;
    logic [7:0] gpio_s2_ff;
    logic [7:0] gpio_s3_ff;
    logic cmp_ff;
    logic [7:0] pin_val_ff;
    logic [7:0] pin_oe_ff;
    logic [31:0] sel_all;
    logic [1:0] nxt_route [8];
    logic wr_rbt;
    logic sw_start;
    logic pin_edge;
    logic trig_start;
    logic [2:0] rsel;
    logic [2:0] csel;
    grr_seq_t seq;

    // ======================================================================
    // register port
    assign wr_rbt = reg_wr_in && (reg_cmd_in == `GRR_CMD_RBT);

    // reserved bits never stored, so they read back as zero
    always_ff @(posedge mclk_in) begin
        if (!rst_n_in) begin
            inv_ff <= `GRR_RST_INV;
            sel14_ff <= `GRR_RST_SEL14;
            sel58_ff <= `GRR_RST_SEL58;
            gpi_ff <= `GRR_RST_GPI;
        end else if (reg_wr_in) begin
            case (reg_cmd_in)
                `GRR_CMD_INV: inv_ff <= reg_wdata_in & `GRR_MSK_INV;
                `GRR_CMD_SEL14: sel14_ff <= reg_wdata_in;
                `GRR_CMD_SEL58: sel58_ff <= reg_wdata_in;
                // host-written reserved bits dropped
                `GRR_CMD_GPI: gpi_ff <= reg_wdata_in & `GRR_MSK_GPI;
                default: ;
            endcase
        end
    end

    // request bit stays set after the reboot; only software clears it
    always_ff @(posedge mclk_in) begin
        if (!rst_n_in) begin
            rbt_ff <= `GRR_RST_RBT;
        end else if (wr_rbt) begin
            rbt_ff <= reg_wdata_in[7:0] & `GRR_MSK_RBT;
        end
    end

    always_ff @(posedge mclk_in) begin
        if (!rst_n_in) begin
            rdata_ff <= 16'h0000;
            ack_ff <= 1'b0;
        end else begin
            ack_ff <= 1'b0;
            if (reg_rd_in) begin
                ack_ff <= 1'b1;
                case (reg_cmd_in)
                    `GRR_CMD_INV: rdata_ff <= inv_ff;
                    `GRR_CMD_SEL14: rdata_ff <= sel14_ff;
                    `GRR_CMD_SEL58: rdata_ff <= sel58_ff;
                    `GRR_CMD_GPI: rdata_ff <= gpi_ff;
                    `GRR_CMD_RBT: rdata_ff <= {8'h00, rbt_ff};
                    default: begin
                        rdata_ff <= 16'h0000;
                        ack_ff <= 1'b0;
                    end
                endcase
            end else if (reg_wr_in) begin
                ack_ff <= (reg_cmd_in == `GRR_CMD_INV)
                    || (reg_cmd_in == `GRR_CMD_SEL14)
                    || (reg_cmd_in == `GRR_CMD_SEL58)
                    || (reg_cmd_in == `GRR_CMD_GPI) || wr_rbt;
            end
        end
    end

    assign reg_rdata_out = rdata_ff;
    assign reg_ack_out = ack_ff;

    // ======================================================================
    // output routing
    function automatic logic [1:0] grr_route(input logic [3:0] sel,
            input int idx, input logic data, input grr_src_t src);
        logic [1:0] r;
        r = 2'b00;
        case (sel)
            `GRR_SRC_DATA: r = {1'b1, data};
            `GRR_SRC_CMP: r = {1'b1, src.comparator_result};
            `GRR_SRC_PG: r = {1'b1, src.power_good_flag};
            `GRR_SRC_FLT: r = {1'b1, src.fault};
            `GRR_SRC_OC: r = {1'b1, src.overcurrent_status};
            `GRR_SRC_OPS: r = {1'b1, src.operation_status_one};
            `GRR_SRC_ALT: r = {1'b1, src.alert};
            `GRR_SRC_LALT: r = {1'b1, src.latched_alert};
            `GRR_SRC_TEMP: begin
                if (idx == `GRR_TEMP_PIN) begin
                    r = {1'b1, src.temperature};
                end
            end
            default: r = 2'b00;
        endcase
        return r;
    endfunction : grr_route

    assign sel_all = {sel58_ff, sel14_ff};

    for (genvar i = 0; i < 8; i++) begin : g_pin
        assign nxt_route[i] = grr_route(sel_all[i*4 +: 4], i,
            general_output_data_in[i], status_src_in);
        always_ff @(posedge mclk_in) begin
            if (!rst_n_in) begin
                pin_val_ff[i] <= 1'b0;
                pin_oe_ff[i] <= 1'b0;
            end else begin
                pin_val_ff[i] <= nxt_route[i][0] ^ inv_ff[i];
                pin_oe_ff[i] <= nxt_route[i][1];
            end
        end
    end

    assign gpio_pin_out = pin_val_ff;
    assign gpio_pin_oe_out = pin_oe_ff;

    // ======================================================================
    // input routing
    always_ff @(posedge mclk_in) begin
        if (!rst_n_in) begin
            gpio_s1_ff <= 8'h00;
            gpio_s2_ff <= 8'h00;
            gpio_s3_ff <= 8'h00;
        end else begin
            gpio_s1_ff <= gpio_pin_in;
            gpio_s2_ff <= gpio_s1_ff;
            gpio_s3_ff <= gpio_s2_ff;
        end
    end

    assign csel = gpi_ff[`GRR_GPI_CSEL_LSB +: 3];
    assign rsel = gpi_ff[`GRR_GPI_RSEL_LSB +: 3];

    always_ff @(posedge mclk_in) begin
        if (!rst_n_in) begin
            cmp_ff <= 1'b0;
        end else begin
            cmp_ff <= gpio_s2_ff[csel];
        end
    end

    assign comparator_in_out = cmp_ff;

    // ======================================================================
    // reboot triggers
    // edge taken on the synchronised level, so a pin glitch shorter than
    // a clock may be missed; the trigger is a slow board signal anyway
    assign pin_edge = gpi_ff[`GRR_GPI_EN_BIT]
        && (inv_ff[`GRR_INV_RPOL_BIT]
            ? (gpio_s3_ff[rsel] && !gpio_s2_ff[rsel])
            : (!gpio_s3_ff[rsel] && gpio_s2_ff[rsel]));
    assign sw_start = wr_rbt && reg_wdata_in[`GRR_RBT_REQ_BIT];
    assign trig_start = sw_start || pin_edge;

    grr_reboot_seq #(
        .OFF_DELAY_CYC(OFF_DELAY_CYC)
    ) u_seq (
        .mclk_in(mclk_in),
        .rst_n_in(rst_n_in),
        .start_in(trig_start),
        .init_opt_in(sw_start ? reg_wdata_in[`GRR_REBOOT_INIT_OPTION_LSB +: 2]
            : rbt_ff[`GRR_REBOOT_INIT_OPTION_LSB +: 2]),
        .seq_out(seq)
    );

    assign fet_off_out = seq.fet_off;
    assign chip_reset_out = seq.chip_reset;
    assign reboot_busy_out = seq.busy;

    // ======================================================================
    // checks
    default clocking cb @(posedge mclk_in); endclocking
    default disable iff (!rst_n_in);

    pin_off_a: assert property (sel14_ff[3:0] == `GRR_SRC_OFF
        |=> !gpio_pin_oe_out[0]) else $error("pin 1 driven while off");
    pin_data_a: assert property (sel14_ff[3:0] == `GRR_SRC_DATA
        |=> gpio_pin_oe_out[0] && gpio_pin_out[0] ==
            ($past(general_output_data_in[0]) ^ $past(inv_ff[0])))
        else $error("pin 1 data wrong");
    temp_pin_a: assert property (sel14_ff[3:0] == `GRR_SRC_TEMP
        |=> !gpio_pin_oe_out[0]) else $error("temp code on pin 1 drove");
    sel_write_a: assert property (reg_wr_in
        && reg_cmd_in == `GRR_CMD_SEL14 |=> sel14_ff == $past(reg_wdata_in))
        else $error("selector write lost");
    gpi_resv_a: assert property (reg_rd_in
        && reg_cmd_in == `GRR_CMD_GPI |=> reg_ack_out
            && !reg_rdata_out[3] && !reg_rdata_out[15])
        else $error("reserved routing bits nonzero");
    sw_reboot_a: assert property (sw_start && !reboot_busy_out
        |=> fet_off_out && rbt_ff[`GRR_RBT_REQ_BIT])
        else $error("software reboot not started");
    req_stays_a: assert property (rbt_ff[`GRR_RBT_REQ_BIT]
        && !wr_rbt |=> rbt_ff[`GRR_RBT_REQ_BIT])
        else $error("request bit cleared by hardware");
    pin_trig_a: assert property (pin_edge && !reboot_busy_out
        |=> fet_off_out) else $error("pin trigger ignored");
    // checked against the raw pin three samples back, not the sync chain
    comparator_pin_selector_a: assert property ($past(rst_n_in, 2) && $past(rst_n_in)
        && csel == $past(csel) && csel == $past(csel, 2)
        |=> comparator_in_out == $past(gpio_pin_in[csel], 3))
        else $error("comparator pin wrong");

    sw_cycle_c: cover property (sw_start ##1 fet_off_out);
    pin_cycle_c: cover property (pin_edge ##1 fet_off_out);
    chip_rst_c: cover property (chip_reset_out);
    temp_drv_c: cover property (gpio_pin_oe_out[`GRR_TEMP_PIN]
        && sel14_ff[11:8] == `GRR_SRC_TEMP);
endmodule : grr_route_reboot

// File: grr_board_model.sv
// ==========================================================================
// board side of the pins
module grr_board_model (
    input wire logic [7:0] oe_in,
    input wire logic [7:0] drive_in,
    input wire logic [7:0] ext_in,
    output logic [7:0] level_out
);
    timeunit 1ns;
    timeprecision 1ps;
    // a driven pin follows the device; an undriven one follows the board
    assign level_out = (oe_in & drive_in) | (~oe_in & ext_in);
endmodule : grr_board_model

// File: grr_route_reboot_tb.sv
`include "grr_params.svh"

module grr_route_reboot_tb import grr_pkg::*; ;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int OFF_CYC = 16;
    logic mclk_in = 1'b0;
    logic rst_n_in = 1'b0;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic [7:0] cmd = 8'h00;
    logic [15:0] wdata = 16'h0000;
    logic [7:0] gdata = 8'h00;
    logic [7:0] src = 8'h00;
    logic [7:0] ext = 8'h00;
    logic [7:0] level;
    logic [15:0] rdata;
    logic ack, cmp, fet_off, chip_reset, busy;
    logic [7:0] pin_out, pin_oe;
    int failures = 0;
    int tests_run = 0;

    always #4 mclk_in = ~mclk_in;

    grr_route_reboot #(.OFF_DELAY_CYC(OFF_CYC)) dut (
        .mclk_in(mclk_in), .rst_n_in(rst_n_in),
        .reg_wr_in(wr), .reg_rd_in(rd), .reg_cmd_in(cmd),
        .reg_wdata_in(wdata), .reg_rdata_out(rdata), .reg_ack_out(ack),
        .general_output_data_in(gdata), .status_src_in(src),
        .gpio_pin_in(level), .gpio_pin_out(pin_out),
        .gpio_pin_oe_out(pin_oe), .comparator_in_out(cmp),
        .fet_off_out(fet_off), .chip_reset_out(chip_reset),
        .reboot_busy_out(busy));

    grr_board_model board (
        .oe_in(pin_oe), .drive_in(pin_out), .ext_in(ext),
        .level_out(level));

    // ======================================================================
    // checking and register access
    task automatic chk(input string name, input logic [15:0] exp,
                       input logic [15:0] got);
        tests_run++;
        if (got !== exp) begin
            failures++;
            $display("unexpected %s: expected %h seen %h", name, exp, got);
        end
    endtask : chk

    task automatic tally_and_finish();
        $display("checks %0d failures %0d", tests_run, failures);
        if (failures == 0 && tests_run > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : tally_and_finish

    task automatic reg_write(input logic [7:0] c, input logic [15:0] d);
        @(posedge mclk_in);
        #1;
        cmd = c;
        wdata = d;
        wr = 1'b1;
        @(posedge mclk_in);
        #1;
        wr = 1'b0;
        chk("write ack", 16'h0001, {15'h0000, ack});
    endtask : reg_write

    task automatic reg_read(input logic [7:0] c, input logic [15:0] exp,
                            input logic exp_ack);
        @(posedge mclk_in);
        #1;
        cmd = c;
        rd = 1'b1;
        @(posedge mclk_in);
        #1;
        rd = 1'b0;
        chk("read ack", {15'h0000, exp_ack}, {15'h0000, ack});
        chk("read data", exp, rdata);
    endtask : reg_read

    function automatic logic [1:0] pin_exp(input int idx, input logic [3:0] c,
                                           input logic pol);
        logic s;
        logic oe;
        oe = 1'b1;
        s = 1'b0;
        case (c)
            4'h1: s = gdata[idx];
            4'h2: s = src[0];
            4'h3: s = src[1];
            4'h4: s = src[2];
            4'h5: s = src[3];
            4'h8: s = src[4];
            4'h9: s = src[5];
            4'hA: s = src[6];
            4'hF: begin
                s = src[7];
                oe = (idx == 2);
            end
            default: oe = 1'b0;
        endcase
        return {oe, oe & (s ^ pol)};
    endfunction : pin_exp

    task automatic idle_check(input int n);
        repeat (n) @(posedge mclk_in);
        #1;
        chk("no trigger", 16'h0000, {15'h0000, fet_off});
    endtask : idle_check

    // off period is counted at the ports; a hang stops the run
    task automatic reboot_run(input logic exp_rst);
        int n;
        n = 0;
        while (fet_off !== 1'b1 && n < 8) begin
            @(posedge mclk_in);
            #1;
            n++;
        end
        chk("fet off start", 16'h0001, {15'h0000, fet_off});
        chk("busy start", 16'h0001, {15'h0000, busy});
        if (fet_off !== 1'b1) tally_and_finish();
        n = 0;
        while (fet_off === 1'b1 && n < 100) begin
            @(posedge mclk_in);
            #1;
            n++;
        end
        chk("off cycles", OFF_CYC[15:0], n[15:0]);
        if (n >= 100) tally_and_finish();
        chk("chip reset", {15'h0000, exp_rst}, {15'h0000, chip_reset});
        @(posedge mclk_in);
        #1;
        chk("busy end", 16'h0000, {15'h0000, busy});
        chk("reset pulse", 16'h0000, {15'h0000, chip_reset});
    endtask : reboot_run

    // ======================================================================
    // main sequence
    initial begin
        logic [1:0] e;
        logic [15:0] opt;
        repeat (6) @(posedge mclk_in);
        #1;
        rst_n_in = 1'b1;
        reg_read(`GRR_CMD_SEL14, 16'h5F43, 1'b1);
        reg_read(`GRR_CMD_SEL58, 16'h8207, 1'b1);
        reg_read(`GRR_CMD_GPI, 16'h0005, 1'b1);
        reg_read(`GRR_CMD_RBT, 16'h0000, 1'b1);
        reg_read(`GRR_CMD_INV, 16'h009B, 1'b1);
        reg_read(8'hF0, 16'h0000, 1'b0);
        reg_write(`GRR_CMD_GPI, 16'h8008);
        reg_read(`GRR_CMD_GPI, 16'h0000, 1'b1);
        reg_write(`GRR_CMD_RBT, 16'h00C0);
        reg_read(`GRR_CMD_RBT, 16'h0000, 1'b1);
        // every code on every pin, both polarities
        for (int p = 0; p < 2; p++) begin
            src = p ? 8'h5A : 8'hA5;
            gdata = p ? 8'hC3 : 8'h3C;
            reg_write(`GRR_CMD_INV, p ? 16'h00FF : 16'h0000);
            for (int c = 0; c < 16; c++) begin
                reg_write(`GRR_CMD_SEL14, {4{c[3:0]}});
                reg_write(`GRR_CMD_SEL58, {4{c[3:0]}});
                @(posedge mclk_in);
                #1;
                for (int i = 0; i < 8; i++) begin
                    e = pin_exp(i, c[3:0], p[0]);
                    chk($sformatf("pin %0d", i), {14'h0000, e},
                        {14'h0000, pin_oe[i], pin_oe[i] & pin_out[i]});
                end
            end
        end
        reg_write(`GRR_CMD_SEL14, 16'h0000);
        reg_write(`GRR_CMD_SEL58, 16'h0000);
        for (int c = 0; c < 8; c++) begin
            reg_write(`GRR_CMD_GPI, {13'h0000, c[2:0]});
            ext = 8'h01 << c;
            repeat (3) @(posedge mclk_in);
            #1;
            chk("comparator high", 16'h0001, {15'h0000, cmp});
            ext = ~(8'h01 << c);
            repeat (3) @(posedge mclk_in);
            #1;
            chk("comparator low", 16'h0000, {15'h0000, cmp});
        end
        // pin trigger on pin 4
        ext = 8'h00;
        reg_write(`GRR_CMD_INV, 16'h0000);
        reg_write(`GRR_CMD_GPI, 16'h00B5);
        ext[2] = 1'b1;
        idle_check(8);
        ext[3] = 1'b1;
        reboot_run(1'b1);
        ext[3] = 1'b0;
        idle_check(8);
        reg_write(`GRR_CMD_INV, 16'h0200);
        reg_write(`GRR_CMD_RBT, 16'h0020);
        ext[3] = 1'b1;
        idle_check(8);
        ext[3] = 1'b0;
        reboot_run(1'b0);
        // pin trigger moved to pin 8, still falling edge
        ext[7] = 1'b1;
        reg_write(`GRR_CMD_GPI, 16'h00F5);
        ext[3] = 1'b1;
        idle_check(8);
        ext[7] = 1'b0;
        reboot_run(1'b0);
        reg_write(`GRR_CMD_GPI, 16'h0005);
        // software reboot with init options 0, 1 and 2
        for (int k = 0; k < 3; k++) begin
            opt = 16'h0008 | (k[15:0] << 4);
            reg_write(`GRR_CMD_RBT, opt);
            reboot_run(k != 2);
            reg_read(`GRR_CMD_RBT, opt, 1'b1);
        end
        tally_and_finish();
    end
endmodule : grr_route_reboot_tb
